// ===== ttg_pkg.sv
// Purpose: shared constants and types for the thermal telemetry and gain control block
// Assumes: AHB-Lite register access, 10 MHz hclk, 16-bit telemetry words
// Notes: byte offsets of the register map are listed below
// Behaviour
// - three gain modes: fixed high, fixed low, automatic; fixed high after reset
// - fixed modes hold their gain state and never switch automatically
// - auto: go low gain when hot-pixel percentage exceeds high-to-low population threshold
// - auto: go high gain when cold-pixel percentage exceeds low-to-high population threshold
// - conditions are evaluated only over pixels inside the gain region of interest
// - automatic gain may be selected only while radiometry is enabled
// - with external or manual correction, a gain switch starts no correction
// - telemetry modes: disabled by default, header before video, footer after video
// - telemetry mode changes only on an explicit control command
// - row A word 0: format revision, major upper byte, minor lower byte
// - row A words 1-2: 32-bit milliseconds since boot
// - row A words 3-4: the two status words
// - row A words 20-21: 32-bit count of output frames
// - row A: sensor temp words 23-24, housing temp words 25-26, counts then kelvin x100
// - each completed correction latches sensor temp, time and housing temp into row A
// - row A words 34-37: contrast-stretch region top, left, bottom, right
// - row A words 72-73: current video output format setting
// - row A word 74: log2 of frames integrated per correction
// - row B: emissivity 19, background 20, transmission 21, atmosphere 22
// - row C word 5: gain mode, 0 high, 1 low, 2 auto
// - row C word 6: effective gain state, 0 high, 1 low
// - row C word 7: 1 when a gain switch is desired
package ttg_pkg;
  localparam int ROW_WORDS = 80;
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int PCT_FULL = 100;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GTHR = 8'h04;
  localparam logic [7:0] A_GPOP = 8'h08;
  localparam logic [7:0] A_GROI0 = 8'h0C;
  localparam logic [7:0] A_GROI1 = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_CSROI0 = 8'h18;
  localparam logic [7:0] A_CSROI1 = 8'h1C;
  localparam logic [7:0] A_VFMT = 8'h20;
  localparam logic [7:0] A_RADB0 = 8'h24;
  localparam logic [7:0] A_RADB1 = 8'h28;
  localparam logic [7:0] A_TELCMD = 8'h2C;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_FRMS = 8'h34;
  // control register and telemetry command register fields
  localparam int CTRL_GMODE_LSB = 0;
  localparam int CTRL_RAD_BIT = 2;
  localparam int CTRL_EXTFFC_BIT = 3;
  localparam int CTRL_LOG2_LSB = 4;
  localparam int TELCMD_GO_BIT = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0030;
  localparam logic [15:0] REV_RST = 16'h0000;
  // row A word indices
  localparam int WA_REV = 0;
  localparam int WA_MS = 1;
  localparam int WA_ST = 3;
  localparam int WA_FRM = 20;
  localparam int WA_SENS = 23;
  localparam int WA_HOUS = 25;
  localparam int WA_FSENS = 29;
  localparam int WA_FMS = 30;
  localparam int WA_FHOUS = 32;
  localparam int WA_CSROI = 34;
  localparam int WA_VFMT = 72;
  localparam int WA_LOG2 = 74;
  // row B and C
  localparam int WB_EMIS = 19;
  localparam int WC_GMODE = 5;
  localparam int WC_GEFF = 6;
  localparam int WC_GDES = 7;
  typedef enum logic [1:0] {GM_HIGH, GM_LOW, GM_AUTO} ttg_gmode_e;
  typedef enum logic [1:0] {TM_OFF, TM_HEADER, TM_FOOTER} ttg_tmode_e;
  typedef struct packed {
    logic valid;
    logic [6:0] row;
    logic [6:0] col;
    logic [15:0] temp;
  } ttg_pix_s;
  typedef struct packed {
    logic [15:0] sens_cnt;
    logic [15:0] sens_k;
    logic [15:0] hous_cnt;
    logic [15:0] hous_k;
  } ttg_temp_s;
endpackage : ttg_pkg

// ===== ttg_core.sv
// Purpose: gain-state selection and telemetry row A/B/C generation, AHB-Lite registers
// Assumes: pixel stream and frame/correction events come from logic on hclk
// Notes: zero wait state slave; telemetry words are produced on request by row and index
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
module ttg_core #(
  parameter logic [15:0] TEL_REV = 16'h0101, // arbitrary value
  parameter int NUM_ROWS = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ttg_pkg::ttg_pix_s pix,
  input wire logic frame_end,
  input wire logic ffc_done,
  input wire ttg_pkg::ttg_temp_s temps,
  input wire logic [31:0] status_words,
  input wire logic tel_req,
  input wire logic [1:0] tel_row,
  input wire logic [6:0] tel_idx,
  output logic [15:0] tel_word,
  output logic tel_valid,
  output logic [1:0] tel_mode,
  output logic gain_low,
  output logic gain_switch_desired,
  output logic ffc_request
);
  // control state
  logic [31:0] ctrl_r;
  logic [31:0] gthr_r, gpop_r, groi0_r, groi1_r, csroi0_r, csroi1_r, vfmt_r, radb0_r, radb1_r;
  logic [1:0] tmode_r;
  logic gain_low_r, des_r;
  logic [31:0] ms_r, frames_r, ms_snap_r, frames_snap_r;
  logic [31:0] ffc_ms_r;
  logic [15:0] ffc_sens_r, ffc_hous_r;
  logic [$clog2(ttg_pkg::MS_CYCLES)-1:0] ms_div_r;
  logic [12:0] roi_cnt_r, hot_cnt_r, cold_cnt_r;
  // bus address phase capture
  logic wr_pend_r;
  logic [7:0] wa_r;
  logic [1:0] gm;
  logic in_roi, go_low, go_high, auto_on;

  function automatic logic over_pct(input logic [12:0] n, input logic [12:0] tot,
      input logic [15:0] pct);
    over_pct = (32'(n) * ttg_pkg::PCT_FULL) > (32'(tot) * 32'(pct));
  endfunction

  assign gm = ctrl_r[ttg_pkg::CTRL_GMODE_LSB +: 2];
  assign auto_on = (gm == 2'(ttg_pkg::GM_AUTO)) && ctrl_r[ttg_pkg::CTRL_RAD_BIT];
  assign in_roi = pix.valid && pix.row >= groi0_r[6:0] && pix.col >= groi0_r[22:16]
    && pix.row <= groi1_r[6:0] && pix.col <= groi1_r[22:16];
  assign go_low = over_pct(hot_cnt_r, roi_cnt_r, gpop_r[15:0]);
  assign go_high = over_pct(cold_cnt_r, roi_cnt_r, gpop_r[31:16]);

  // ahb write path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wa_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= ttg_pkg::CTRL_RST;
      gthr_r <= 32'h0000_0000;
      gpop_r <= 32'h0000_0000;
      groi0_r <= 32'h0000_0000;
      groi1_r <= 32'h0000_0000;
      csroi0_r <= 32'h0000_0000;
      csroi1_r <= 32'h0000_0000;
      vfmt_r <= 32'h0000_0000;
      radb0_r <= 32'h0000_0000;
      radb1_r <= 32'h0000_0000;
    end else if (wr_pend_r) begin
      case (wa_r)
        ttg_pkg::A_CTRL: begin
          // auto selection refused while radiometry is off: keep old mode
          if (hwdata[1:0] == 2'(ttg_pkg::GM_AUTO) && !hwdata[ttg_pkg::CTRL_RAD_BIT])
            ctrl_r <= {hwdata[31:2], ctrl_r[1:0]};
          else if (hwdata[1:0] == 2'h3)
            ctrl_r <= {hwdata[31:2], ctrl_r[1:0]};
          else
            ctrl_r <= hwdata;
        end
        ttg_pkg::A_GTHR: gthr_r <= hwdata;
        ttg_pkg::A_GPOP: gpop_r <= hwdata;
        ttg_pkg::A_GROI0: groi0_r <= hwdata;
        ttg_pkg::A_GROI1: groi1_r <= hwdata;
        ttg_pkg::A_CSROI0: csroi0_r <= hwdata;
        ttg_pkg::A_CSROI1: csroi1_r <= hwdata;
        ttg_pkg::A_VFMT: vfmt_r <= hwdata;
        ttg_pkg::A_RADB0: radb0_r <= hwdata;
        ttg_pkg::A_RADB1: radb1_r <= hwdata;
        default: ;
      endcase
    end
  end

  // telemetry mode only moves on an explicit command write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tmode_r <= 2'(ttg_pkg::TM_OFF);
    else if (wr_pend_r && wa_r == ttg_pkg::A_TELCMD && hwdata[ttg_pkg::TELCMD_GO_BIT]
        && hwdata[1:0] != 2'h3)
      tmode_r <= hwdata[1:0];
  end

  // millisecond time base and frame counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_div_r <= '0;
      ms_r <= 32'h0000_0000;
      frames_r <= 32'h0000_0000;
      ms_snap_r <= 32'h0000_0000;
      frames_snap_r <= 32'h0000_0000;
    end else begin
      if (ms_div_r == ($clog2(ttg_pkg::MS_CYCLES))'(ttg_pkg::MS_CYCLES - 1)) begin
        ms_div_r <= '0;
        ms_r <= ms_r + 32'h0000_0001;
      end else begin
        ms_div_r <= ms_div_r + ($clog2(ttg_pkg::MS_CYCLES))'(1);
      end
      if (frame_end) begin
        frames_r <= frames_r + 32'h0000_0001;
        ms_snap_r <= ms_r;
        frames_snap_r <= frames_r + 32'h0000_0001;
      end
    end
  end

  // values latched at each completed correction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ffc_ms_r <= 32'h0000_0000;
      ffc_sens_r <= 16'h0000;
      ffc_hous_r <= 16'h0000;
    end else if (ffc_done) begin
      ffc_ms_r <= ms_r;
      ffc_sens_r <= temps.sens_k;
      ffc_hous_r <= temps.hous_k;
    end
  end

  // region population counters, cleared at each frame end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roi_cnt_r <= 13'h0000;
      hot_cnt_r <= 13'h0000;
      cold_cnt_r <= 13'h0000;
    end else if (frame_end) begin
      roi_cnt_r <= 13'h0000;
      hot_cnt_r <= 13'h0000;
      cold_cnt_r <= 13'h0000;
    end else if (in_roi) begin
      roi_cnt_r <= roi_cnt_r + 13'h0001;
      if (pix.temp > gthr_r[15:0])
        hot_cnt_r <= hot_cnt_r + 13'h0001;
      if (pix.temp < gthr_r[31:16])
        cold_cnt_r <= cold_cnt_r + 13'h0001;
    end
  end

  // gain state: fixed modes follow the control register every cycle, auto decided once per frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_low_r <= 1'b0;
      des_r <= 1'b0;
      ffc_request <= 1'b0;
    end else begin
      ffc_request <= 1'b0;
      case (gm)
        2'(ttg_pkg::GM_HIGH): begin
          gain_low_r <= 1'b0;
          des_r <= 1'b0;
        end
        2'(ttg_pkg::GM_LOW): begin
          gain_low_r <= 1'b1;
          des_r <= 1'b0;
        end
        default: begin
          if (auto_on && frame_end && roi_cnt_r != 13'h0000) begin
            des_r <= gain_low_r ? go_high : go_low;
            if (!gain_low_r && go_low) begin
              gain_low_r <= 1'b1;
              ffc_request <= !ctrl_r[ttg_pkg::CTRL_EXTFFC_BIT];
            end else if (gain_low_r && go_high) begin
              gain_low_r <= 1'b0;
              ffc_request <= !ctrl_r[ttg_pkg::CTRL_EXTFFC_BIT];
            end
          end
        end
      endcase
    end
  end

  // telemetry word mux, one-cycle latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tel_word <= 16'h0000;
      tel_valid <= 1'b0;
    end else begin
      tel_valid <= tel_req;
      tel_word <= 16'h0000;
      if (tel_req && 32'(tel_row) < NUM_ROWS && 32'(tel_idx) < ttg_pkg::ROW_WORDS) begin
        case (tel_row)
          2'd0: begin
            case (32'(tel_idx))
              ttg_pkg::WA_REV: tel_word <= TEL_REV;
              ttg_pkg::WA_MS: tel_word <= ms_snap_r[15:0];
              ttg_pkg::WA_MS + 1: tel_word <= ms_snap_r[31:16];
              ttg_pkg::WA_ST: tel_word <= status_words[15:0];
              ttg_pkg::WA_ST + 1: tel_word <= status_words[31:16];
              ttg_pkg::WA_FRM: tel_word <= frames_snap_r[15:0];
              ttg_pkg::WA_FRM + 1: tel_word <= frames_snap_r[31:16];
              ttg_pkg::WA_SENS: tel_word <= temps.sens_cnt;
              ttg_pkg::WA_SENS + 1: tel_word <= temps.sens_k;
              ttg_pkg::WA_HOUS: tel_word <= temps.hous_cnt;
              ttg_pkg::WA_HOUS + 1: tel_word <= temps.hous_k;
              ttg_pkg::WA_FSENS: tel_word <= ffc_sens_r;
              ttg_pkg::WA_FMS: tel_word <= ffc_ms_r[15:0];
              ttg_pkg::WA_FMS + 1: tel_word <= ffc_ms_r[31:16];
              ttg_pkg::WA_FHOUS: tel_word <= ffc_hous_r;
              ttg_pkg::WA_CSROI: tel_word <= csroi0_r[15:0];
              ttg_pkg::WA_CSROI + 1: tel_word <= csroi0_r[31:16];
              ttg_pkg::WA_CSROI + 2: tel_word <= csroi1_r[15:0];
              ttg_pkg::WA_CSROI + 3: tel_word <= csroi1_r[31:16];
              ttg_pkg::WA_VFMT: tel_word <= vfmt_r[15:0];
              ttg_pkg::WA_VFMT + 1: tel_word <= vfmt_r[31:16];
              ttg_pkg::WA_LOG2: tel_word <= {13'h0000, ctrl_r[ttg_pkg::CTRL_LOG2_LSB +: 3]};
              default: tel_word <= 16'h0000;
            endcase
          end
          2'd1: begin
            case (32'(tel_idx))
              ttg_pkg::WB_EMIS: tel_word <= radb0_r[15:0];
              ttg_pkg::WB_EMIS + 1: tel_word <= radb0_r[31:16];
              ttg_pkg::WB_EMIS + 2: tel_word <= radb1_r[15:0];
              ttg_pkg::WB_EMIS + 3: tel_word <= radb1_r[31:16];
              default: tel_word <= 16'h0000;
            endcase
          end
          default: begin
            case (32'(tel_idx))
              ttg_pkg::WC_GMODE: tel_word <= {14'h0000, gm};
              ttg_pkg::WC_GEFF: tel_word <= {15'h0000, gain_low_r};
              ttg_pkg::WC_GDES: tel_word <= {15'h0000, des_r};
              default: tel_word <= 16'h0000;
            endcase
          end
        endcase
      end
    end
  end

  // ahb read data, registered in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        ttg_pkg::A_CTRL: hrdata <= ctrl_r;
        ttg_pkg::A_GTHR: hrdata <= gthr_r;
        ttg_pkg::A_GPOP: hrdata <= gpop_r;
        ttg_pkg::A_GROI0: hrdata <= groi0_r;
        ttg_pkg::A_GROI1: hrdata <= groi1_r;
        ttg_pkg::A_CSROI0: hrdata <= csroi0_r;
        ttg_pkg::A_CSROI1: hrdata <= csroi1_r;
        ttg_pkg::A_VFMT: hrdata <= vfmt_r;
        ttg_pkg::A_RADB0: hrdata <= radb0_r;
        ttg_pkg::A_RADB1: hrdata <= radb1_r;
        ttg_pkg::A_TELCMD: hrdata <= {30'h0000_0000, tmode_r};
        ttg_pkg::A_STAT: hrdata <= {29'h0000_0000, des_r, gain_low_r, auto_on};
        ttg_pkg::A_FRMS: hrdata <= frames_r;
        ttg_pkg::A_STATUS: hrdata <= ms_r;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // flop the simple outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      tel_mode <= 2'(ttg_pkg::TM_OFF);
      gain_low <= 1'b0;
      gain_switch_desired <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      tel_mode <= tmode_r;
      gain_low <= gain_low_r;
      gain_switch_desired <= des_r;
    end
  end
endmodule // ttg_core

// ===== ttg_core_props.sv
// Purpose: port-level assertions for the telemetry and gain block
// Assumes: one hclk domain, hresetn asynchronous active low
// Notes: bound to every ttg_core instance
module ttg_core_props #(
  parameter logic [15:0] TEL_REV = 16'h0101
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frame_end,
  input wire ttg_pkg::ttg_temp_s temps,
  input wire logic [31:0] status_words,
  input wire logic tel_req,
  input wire logic [1:0] tel_row,
  input wire logic [6:0] tel_idx,
  input wire logic [15:0] tel_word,
  input wire logic tel_valid,
  input wire logic [1:0] tel_mode,
  input wire logic gain_low,
  input wire logic ffc_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_tel_r, wr_ctrl_r;
  // address phase of a write to the telemetry command or control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_tel_r <= 1'b0;
      wr_ctrl_r <= 1'b0;
    end else begin
      wr_tel_r <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == ttg_pkg::A_TELCMD;
      wr_ctrl_r <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == ttg_pkg::A_CTRL;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_req(logic [1:0] r, logic [6:0] i);
    tel_req && tel_row == r && tel_idx == i;
  endsequence
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  // fixed modes move three cycles after a control write, auto only after a frame end
  a_gain_on_frame: assert property ($changed(gain_low) |->
    $past(frame_end) || $past(frame_end, 2) || $past(wr_ctrl_r, 3))
    else $error("gain changed without a frame end");
  a_ffc_cause: assert property (ffc_request |-> $past(frame_end) || $past(frame_end, 2))
    else $error("correction request without a frame end");
  a_ffc_pulse: assert property (ffc_request |=> !ffc_request)
    else $error("correction request longer than one cycle");
  a_mode_by_cmd: assert property ($changed(tel_mode) |->
    $past(wr_tel_r) || $past(wr_tel_r, 2))
    else $error("telemetry mode changed without a command");
  a_word_valid: assert property (tel_req |=> tel_valid)
    else $error("telemetry word not answered");
  a_rev_word: assert property (s_req(2'h0, 7'h00) |=> tel_word == TEL_REV)
    else $error("revision word wrong");
  a_status_low: assert property (s_req(2'h0, 7'h03) |=>
    tel_word == $past(status_words[15:0]))
    else $error("status word wrong");
  a_sens_count: assert property (s_req(2'h0, 7'h17) |=> tel_word == $past(temps.sens_cnt))
    else $error("sensor count word wrong");
  a_out_of_row: assert property (tel_req && (tel_row == 2'h3 || tel_idx >= 7'h50) |=>
    tel_word == 16'h0000)
    else $error("word outside a row not zero");
endmodule // ttg_core_props

bind ttg_core ttg_core_props #(.TEL_REV(TEL_REV)) u_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .frame_end, .temps, .status_words, .tel_req,
  .tel_row, .tel_idx, .tel_word, .tel_valid, .tel_mode, .gain_low, .ffc_request);

// ===== ttg_frame_src.sv
// Purpose: pixel source standing in for the sensor side, one 8 x 8 frame per start
// Assumes: gain region covers rows 0-3 and cols 0-3
// Notes: idle pixel fields keep toggling so nothing relies on stale values
module ttg_frame_src (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [15:0] t_in,
  input wire logic [15:0] t_out,
  output ttg_pkg::ttg_pix_s pix,
  output logic frame_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r, done_r;
  logic [5:0] n_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix <= '0;
      frame_end <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      n_r <= 6'h00;
    end else if (busy_r) begin
      pix.valid <= 1'b1;
      pix.row <= {4'h0, n_r[5:3]};
      pix.col <= {4'h0, n_r[2:0]};
      pix.temp <= (!n_r[5] && !n_r[2]) ? t_in : t_out;
      n_r <= n_r + 6'h01;
      busy_r <= n_r != 6'h3F;
      done_r <= n_r == 6'h3F;
    end else begin
      pix <= {1'b0, ~pix[29:0]};
      frame_end <= done_r;
      done_r <= 1'b0;
      busy_r <= start;
    end
  end
endmodule // ttg_frame_src

// ===== tb_thermal_telemetry_gain_control.sv
// Purpose: self-checking bench for the telemetry and gain block
// Assumes: zero wait AHB slave, telemetry word one cycle after request
// Notes: gain expectations use an 8 x 8 frame with a 4 x 4 region
module tb_thermal_telemetry_gain_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, frame_end, ffc_done;
  logic tel_req, tel_valid, gain_low, gain_switch_desired, ffc_request, start;
  logic [31:0] haddr, hwdata, hrdata, status_words, rd;
  logic [1:0] htrans, tel_row, tel_mode;
  logic [2:0] hsize;
  logic [6:0] tel_idx;
  logic [15:0] tel_word, t_in, t_out;
  ttg_pkg::ttg_pix_s pix;
  ttg_pkg::ttg_temp_s temps;
  int num_errors, total_checks, nfr, nffc;
  logic [24:0] tab [0:23] = '{
    {2'h0, 7'h00, 16'h0A05}, {2'h0, 7'h03, 16'h1234}, {2'h0, 7'h04, 16'hBEEF},
    {2'h0, 7'h17, 16'h1111}, {2'h0, 7'h18, 16'h7400}, {2'h0, 7'h19, 16'h2222},
    {2'h0, 7'h1A, 16'h7500}, {2'h0, 7'h22, 16'h0001}, {2'h0, 7'h23, 16'h0002},
    {2'h0, 7'h24, 16'h0003}, {2'h0, 7'h25, 16'h0004}, {2'h0, 7'h48, 16'h0005},
    {2'h0, 7'h49, 16'h0006}, {2'h0, 7'h4A, 16'h0003}, {2'h1, 7'h13, 16'h1A00},
    {2'h1, 7'h14, 16'h7530}, {2'h1, 7'h15, 16'h1F00}, {2'h1, 7'h16, 16'h7148},
    {2'h0, 7'h11, 16'h0000}, {2'h1, 7'h00, 16'h0000}, {2'h3, 7'h00, 16'h0000},
    {2'h0, 7'h50, 16'h0000}, {2'h2, 7'h05, 16'h0000}, {2'h2, 7'h06, 16'h0000}};
  assign hready = hreadyout;
  ttg_core #(.TEL_REV(16'h0A05)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pix, .frame_end, .ffc_done, .temps,
    .status_words, .tel_req, .tel_row, .tel_idx, .tel_word, .tel_valid, .tel_mode, .gain_low,
    .gain_switch_desired, .ffc_request);
  ttg_frame_src src_u (.hclk, .hresetn, .start, .t_in, .t_out, .pix, .frame_end);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    nfr += (frame_end === 1'b1);
    nffc += (ffc_request === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task tel(input logic [1:0] r, input logic [6:0] i, input logic [15:0] e);
    @(posedge hclk);
    tel_req <= 1'b1;
    tel_row <= r;
    tel_idx <= i;
    @(posedge hclk);
    tel_req <= 1'b0;
    #1;
    chk({tel_valid, tel_word}, {1'b1, e});
  endtask
  task frame(input logic [15:0] ti, input logic [15:0] to);
    @(posedge hclk);
    t_in <= ti;
    t_out <= to;
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
    @(posedge frame_end);
    // gain output lands within two cycles of the frame end
    repeat (3) @(posedge hclk);
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    num_errors++;
    results;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ffc_done, tel_req, start} = '0;
    {tel_row, tel_idx, t_in, t_out} = '0;
    hsize = 3'h2;
    status_words = 32'hBEEF_1234;
    temps = {16'h1111, 16'h7400, 16'h2222, 16'h7500};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({tel_mode, gain_low}, 3'h0);
    ahb(1'b0, ttg_pkg::A_CTRL, 32'h0);
    chk(rd, ttg_pkg::CTRL_RST);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, ttg_pkg::A_CSROI0, 32'h0002_0001);
    ahb(1'b1, ttg_pkg::A_CSROI1, 32'h0004_0003);
    ahb(1'b1, ttg_pkg::A_VFMT, 32'h0006_0005);
    ahb(1'b1, ttg_pkg::A_RADB0, 32'h7530_1A00);
    ahb(1'b1, ttg_pkg::A_RADB1, 32'h7148_1F00);
    foreach (tab[k])
      tel(tab[k][24:23], tab[k][22:16], tab[k][15:0]);
    ahb(1'b1, ttg_pkg::A_TELCMD, 32'h1);
    repeat (2) @(posedge hclk);
    chk(tel_mode, 2'h0);
    for (int m = 2; m >= 0; m--) begin
      ahb(1'b1, ttg_pkg::A_TELCMD, 32'h4 | m);
      repeat (2) @(posedge hclk);
      chk(tel_mode, m);
    end
    ahb(1'b1, ttg_pkg::A_GTHR, 32'h01F4_03E8);
    ahb(1'b1, ttg_pkg::A_GPOP, 32'h0032_0032);
    ahb(1'b1, ttg_pkg::A_GROI0, 32'h0);
    ahb(1'b1, ttg_pkg::A_GROI1, 32'h0003_0003);
    ahb(1'b1, ttg_pkg::A_CTRL, 32'h31);
    frame(16'h0064, 16'h0064);
    chk(gain_low, 1'b1);
    ahb(1'b1, ttg_pkg::A_CTRL, 32'h30);
    frame(16'h07D0, 16'h07D0);
    chk(gain_low, 1'b0);
    ahb(1'b1, ttg_pkg::A_CTRL, 32'h32);
    ahb(1'b0, ttg_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h30);
    ahb(1'b1, ttg_pkg::A_CTRL, 32'h3E);
    frame(16'h02BC, 16'h07D0);
    chk({gain_low, gain_switch_desired}, 2'h0);
    frame(16'h07D0, 16'h0064);
    chk({gain_low, 31'(nffc)}, {1'b1, 31'h0});
    chk(gain_switch_desired, 1'b1);
    tel(2'h2, 7'h07, 16'h0001);
    tel(2'h2, 7'h05, 16'h0002);
    tel(2'h2, 7'h06, 16'h0001);
    ahb(1'b1, ttg_pkg::A_CTRL, 32'h37);
    ahb(1'b0, ttg_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h36);
    frame(16'h0064, 16'h07D0);
    chk({gain_low, 31'(nffc)}, {1'b0, 31'h1});
    @(posedge hclk);
    ffc_done <= 1'b1;
    @(posedge hclk);
    ffc_done <= 1'b0;
    temps <= {16'h3333, 16'h7600, 16'h4444, 16'h7700};
    tel(2'h0, 7'h1D, 16'h7400);
    tel(2'h0, 7'h20, 16'h7500);
    tel(2'h0, 7'h14, nfr[15:0]);
    tel(2'h0, 7'h15, 16'h0000);
    // about 20.5k cycles since release: the snapshot must read two milliseconds
    repeat (20_000) @(posedge hclk);
    frame(16'h02BC, 16'h02BC);
    tel(2'h0, 7'h01, 16'h0002);
    tel(2'h0, 7'h02, 16'h0000);
    ahb(1'b1, ttg_pkg::A_TELCMD, 32'h6);
    repeat (2) @(posedge hclk);
    chk(tel_mode, 2'h2);
    // reset in mid-run must bring mode and control back to their defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({tel_mode, gain_low, gain_switch_desired}, 4'h0);
    ahb(1'b0, ttg_pkg::A_CTRL, 32'h0);
    chk(rd, ttg_pkg::CTRL_RST);
    results;
  end
endmodule // tb_thermal_telemetry_gain_control
